// ### core/test_source_pkg.sv
/*
  Constants shared by the test source register bank: register indices,
  field positions, reset values and the level scale of the source outputs.
  Assumes a 32-bit classic Wishbone bus with byte addresses (index * 4).
*/
package test_source_pkg;
  localparam int unsigned  DATA_W         = 32;
  localparam int unsigned  ADR_W          = 8;
  localparam int unsigned  REG_W          = 8;
  localparam int unsigned  CODE_W         = 5;
  localparam int unsigned  LEVEL_W        = 10;

  // register indices; byte address is index * 4
  localparam logic [5:0]   POS_IDX        = 6'h10;
  localparam logic [5:0]   NEG_IDX        = 6'h11;
  localparam logic [5:0]   STATUS_IDX     = 6'h20;

  // field positions inside each source register
  localparam int unsigned  CONNECT_BIT    = 7;
  localparam int unsigned  CODE_MSB       = 4;
  localparam int unsigned  SIGN_BIT       = 4;
  localparam logic [7:0]   REG_RESET      = 8'h00;
  localparam logic [7:0]   WRITE_MASK     = 8'h9f;

  // status register bit positions
  localparam int unsigned  POS_VALID_BIT  = 0;
  localparam int unsigned  NEG_VALID_BIT  = 1;

  // code magnitude range and level scale, level in 1/128 V above the negative supply
  localparam logic [3:0]   MAG_MAX        = 4'h9;
  localparam logic [LEVEL_W-1:0] LEVEL_MID = 10'h140;
endpackage

// ### core/test_source_if.sv
/*
  Carries one test source channel between the register front end and the
  channel register. Assumes both ends share the bank clock.
*/
interface test_source_if;
  logic                                   wr_en;
  logic [test_source_pkg::REG_W-1:0]      wr_data;
  logic [test_source_pkg::REG_W-1:0]      rd_data;
  logic                                   pin_connect;
  logic [test_source_pkg::CODE_W-1:0]     level_code;
  logic [test_source_pkg::LEVEL_W-1:0]    level;
  logic                                   code_valid;

  modport front (output wr_en, output wr_data,
                 input rd_data, input pin_connect, input level_code, input level, input code_valid);
  modport chan  (input wr_en, input wr_data,
                 output rd_data, output pin_connect, output level_code, output level, output code_valid);
endinterface

// ### core/test_source_chan.sv
/*
  One test source control register with its decoded output level.
  Assumes writes arrive as one-cycle strobes on the bank clock.
*/
module test_source_chan (
  input  wire logic        clk_i,   // bank clock
  input  wire logic        rst_i,   // synchronous reset, high
  test_source_if.chan      ch       // channel signals
);
  logic [test_source_pkg::REG_W-1:0]   reg_ff;
  logic [test_source_pkg::REG_W-1:0]   nxt_reg;
  logic [test_source_pkg::LEVEL_W-1:0] level_ff;
  logic [test_source_pkg::LEVEL_W-1:0] nxt_level;
  logic                                valid_ff;
  logic                                nxt_valid;
  logic [3:0]                          mag;
  logic [test_source_pkg::LEVEL_W-1:0] step;

  always_comb begin
    nxt_reg = reg_ff;
    if (ch.wr_en) begin
      // reserved bits 6:5 never store
      nxt_reg = ch.wr_data & test_source_pkg::WRITE_MASK;
    end
    mag  = nxt_reg[3:0];
    step = '0;
    // magnitude k gives 2^(k-1)/128 V away from 2.5 V
    if (mag != 4'h0) begin
      step = test_source_pkg::LEVEL_W'(1) << (mag - 4'h1);
    end
    nxt_valid = (mag <= test_source_pkg::MAG_MAX) &&
                !(nxt_reg[test_source_pkg::SIGN_BIT] && mag == 4'h0);
    if (!nxt_valid) begin
      // reserved code: hold the midpoint rather than an undefined level
      nxt_level = test_source_pkg::LEVEL_MID;
    end else if (nxt_reg[test_source_pkg::SIGN_BIT]) begin
      nxt_level = test_source_pkg::LEVEL_MID - step;
    end else begin
      nxt_level = test_source_pkg::LEVEL_MID + step;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_ff   <= test_source_pkg::REG_RESET;
      level_ff <= test_source_pkg::LEVEL_MID;
      valid_ff <= 1'b1;
    end else begin
      reg_ff   <= nxt_reg;
      level_ff <= nxt_level;
      valid_ff <= nxt_valid;
    end
  end

  assign ch.rd_data     = reg_ff;
  assign ch.pin_connect = reg_ff[test_source_pkg::CONNECT_BIT];
  assign ch.level_code  = reg_ff[test_source_pkg::CODE_MSB:0];
  assign ch.level       = level_ff;
  assign ch.code_valid  = valid_ff;
endmodule

// ### core/test_source_regs.sv
/*
  Wishbone register bank for the positive and negative test voltage sources.
  Assumes a classic single-cycle master; one ack per request, one cycle after it.
*/
// The Wishbone interface to the registers is this design's own decision.
// Summary of operation
// - positive register bit 7 connects positive source to analog input six
// - negative register bit 7 connects negative source to analog input seven
// - positive bits 4:0 are read/write level code, reset zero (2.5 V)
// - negative bits 4:0 same level code encoding, reset zero
// - code sign-magnitude around 2.5 V: 1..9 up to 4.5 V, 17..25 down
// - negative register at index 11h, resets to all zeros
module test_source_regs (
  input  wire logic                                clk_i,                // 50 MHz clock
  input  wire logic                                rst_i,                // synchronous reset, high
  input  wire logic                                cyc_i,                // wishbone cycle
  input  wire logic                                stb_i,                // wishbone strobe
  input  wire logic                                we_i,                 // write enable
  input  wire logic [test_source_pkg::ADR_W-1:0]   adr_i,                // byte address
  input  wire logic [3:0]                          sel_i,                // byte selects
  input  wire logic [test_source_pkg::DATA_W-1:0]  dat_i,                // write data
  output logic      [test_source_pkg::DATA_W-1:0]  dat_o,                // read data
  output logic                                     ack_o,                // acknowledge
  output logic                                     pos_pin_connect_o,    // positive source to input six
  output logic                                     neg_pin_connect_o,    // negative source to input seven
  output logic      [test_source_pkg::CODE_W-1:0]  pos_level_code_o,     // positive level code
  output logic      [test_source_pkg::CODE_W-1:0]  neg_level_code_o,     // negative level code
  output logic      [test_source_pkg::LEVEL_W-1:0] pos_level_o,          // positive level, 1/128 V
  output logic      [test_source_pkg::LEVEL_W-1:0] neg_level_o           // negative level, 1/128 V
);
  test_source_if pos_if ();
  test_source_if neg_if ();

  // the answer phase lasts one cycle, then the slave rests one
  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

  bus_state_t                         state_ff;
  bus_state_t                         nxt_state;
  logic                               req;
  logic                               take;
  logic                               answering;
  logic                               byte0_en;
  logic                               commit;
  logic [5:0]                         idx;
  logic                               hit_pos;
  logic                               hit_neg;
  logic                               hit_status;
  logic [test_source_pkg::REG_W-1:0]  wr_byte;
  logic [test_source_pkg::DATA_W-1:0] pos_word;
  logic [test_source_pkg::DATA_W-1:0] neg_word;
  logic [test_source_pkg::DATA_W-1:0] status_word;
  logic [test_source_pkg::DATA_W-1:0] rdata_ff;
  logic [test_source_pkg::DATA_W-1:0] nxt_rdata;

  assign req       = cyc_i && stb_i;
  assign answering = (state_ff == BUS_ANSWER);
  // a request is taken only while the slave is idle
  assign take      = req && !answering;

  // address bits 1:0 pick a byte lane and are ignored
  always_comb begin
    idx        = adr_i[test_source_pkg::ADR_W-1:2];
    hit_pos    = 1'b0;
    hit_neg    = 1'b0;
    hit_status = 1'b0;
    unique case (idx)
      test_source_pkg::POS_IDX: begin
        hit_pos = 1'b1;
      end
      test_source_pkg::NEG_IDX: begin
        hit_neg = 1'b1;
      end
      test_source_pkg::STATUS_IDX: begin
        hit_status = 1'b1;
      end
      default: begin
        // unmapped: answered with zero, writes dropped
        hit_status = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      BUS_IDLE: begin
        if (req) begin
          nxt_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        // a held request is answered again only after one idle cycle
        nxt_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // write lands on the edge where the master sees ack high
  always_comb begin
    byte0_en = sel_i[0];
    wr_byte  = dat_i[test_source_pkg::REG_W-1:0];
    commit   = req && we_i && answering && byte0_en;
  end

  assign pos_if.wr_en   = commit && hit_pos;
  assign neg_if.wr_en   = commit && hit_neg;
  assign pos_if.wr_data = wr_byte;
  assign neg_if.wr_data = wr_byte;

  test_source_chan u_pos (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ch    (pos_if)
  );

  test_source_chan u_neg (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ch    (neg_if)
  );

  always_comb begin
    pos_word                                = '0;
    pos_word[test_source_pkg::REG_W-1:0]    = pos_if.rd_data;
    neg_word                                = '0;
    neg_word[test_source_pkg::REG_W-1:0]    = neg_if.rd_data;
  end

  // a level code outside the defined set shows as not valid
  always_comb begin
    status_word                                 = '0;
    status_word[test_source_pkg::POS_VALID_BIT] = pos_if.code_valid;
    status_word[test_source_pkg::NEG_VALID_BIT] = neg_if.code_valid;
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (take) begin
      if (hit_pos) begin
        nxt_rdata = pos_word;
      end else if (hit_neg) begin
        nxt_rdata = neg_word;
      end else if (hit_status) begin
        nxt_rdata = status_word;
      end else begin
        nxt_rdata = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign ack_o             = answering;
  assign dat_o             = rdata_ff;
  assign pos_pin_connect_o = pos_if.pin_connect;
  assign neg_pin_connect_o = neg_if.pin_connect;
  assign pos_level_code_o  = pos_if.level_code;
  assign neg_level_code_o  = neg_if.level_code;
  assign pos_level_o       = pos_if.level;
  assign neg_level_o       = neg_if.level;
endmodule

// ### tb/test_source_regs_chk.sv
/* port checker for the test source bank
   assumes one clock; bound to the bank below */
module test_source_regs_chk (
  input wire logic        clk_i,             // clock
  input wire logic        rst_i,             // reset
  input wire logic        cyc_i,             // cycle
  input wire logic        stb_i,             // strobe
  input wire logic        we_i,              // write
  input wire logic [7:0]  adr_i,             // address
  input wire logic [31:0] dat_o,             // read data
  input wire logic        ack_o,             // ack
  input wire logic        pos_pin_connect_o, // pin six
  input wire logic        neg_pin_connect_o, // pin seven
  input wire logic [4:0]  pos_level_code_o,  // code
  input wire logic [4:0]  neg_level_code_o,  // code
  input wire logic [9:0]  pos_level_o,       // level
  input wire logic [9:0]  neg_level_o        // level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; cyc_i && stb_i && !ack_o; endsequence
  sequence ack_s; ack_o ##1 !ack_o; endsequence
  ack_req_a: assert property (req_s |=> ack_s) else $error("ack missing");
  rd_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0 && dat_o[6:5] == 2'h0) else $error("bits 6:5 set");
  pos_write_a: assert property ($changed({pos_pin_connect_o, pos_level_code_o}) |->
    $past(cyc_i && stb_i && we_i && ack_o && adr_i[7:2] == 6'h10)) else $error("pos changed");
  neg_write_a: assert property ($changed({neg_pin_connect_o, neg_level_code_o}) |->
    $past(cyc_i && stb_i && we_i && ack_o && adr_i[7:2] == 6'h11)) else $error("neg changed");
  pos_mid_a: assert property (pos_level_code_o == 5'h0 |-> pos_level_o == 10'h140) else $error("pos mid");
  pos_up_a: assert property (pos_level_code_o inside {[1:9]} |->
    pos_level_o == 10'h140 + (10'h1 << (pos_level_code_o - 1))) else $error("pos level");
  neg_down_a: assert property (neg_level_code_o inside {[17:25]} |->
    neg_level_o == 10'h140 - (10'h1 << (neg_level_code_o - 17))) else $error("neg level");
  neg_reset_a: assert property ($fell(rst_i) |-> !neg_pin_connect_o && neg_level_code_o == 5'h0) else $error("neg reset");
endmodule
bind test_source_regs test_source_regs_chk chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
  .pos_pin_connect_o, .neg_pin_connect_o, .pos_level_code_o, .neg_level_code_o, .pos_level_o, .neg_level_o);

// ### tb/tb_top.sv
/* self-checking bench for the test source bank
   assumes the bank answers each request one cycle later */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00, mdl [2];
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd, d;
  logic        ack_o, pos_pin_connect_o, neg_pin_connect_o;
  logic [4:0]  pos_level_code_o, neg_level_code_o;
  logic [9:0]  pos_level_o, neg_level_o;
  int          errors = 0, total_checks = 0, seed = 35316, r, c;
  always #10 clk_i = ~clk_i;
  test_source_regs dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .pos_pin_connect_o, .neg_pin_connect_o, .pos_level_code_o, .neg_level_code_o, .pos_level_o, .neg_level_o);
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, dd, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      test_done();
    end
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    #1;
  endtask
  function automatic logic [9:0] lvl(input logic [4:0] cc);
    if (cc[3:0] == 4'h0) return 10'h140;
    return cc[4] ? 10'h140 - (10'h1 << (cc[3:0] - 1)) : 10'h140 + (10'h1 << (cc[3:0] - 1));
  endfunction
  task automatic outs();
    check("pos pin", pos_pin_connect_o, mdl[0][7]);
    check("neg pin", neg_pin_connect_o, mdl[1][7]);
    check("pos code", pos_level_code_o, mdl[0][4:0]);
    check("neg code", neg_level_code_o, mdl[1][4:0]);
    check("pos level", pos_level_o, lvl(mdl[0][4:0]));
    check("neg level", neg_level_o, lvl(mdl[1][4:0]));
  endtask
  task automatic reset_seq();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    mdl = '{8'h00, 8'h00};
    #1;
    outs();
    check("reset rdata", dat_o, 32'h0);
    wb(1'b0, 8'h44, 32'h0, 4'hf);
    check("neg reset", rd, 32'h0);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    test_done();
  end
  initial begin
    reset_seq();
    for (int i = 0; i < 38; i++) begin
      r = i % 2;
      c = (i / 2 < 10) ? i / 2 : i / 2 + 7; // defined codes only
      d = $random(seed);
      d[4:0] = c[4:0];
      mdl[r] = d[7:0] & 8'h9f;
      wb(1'b1, r ? 8'h44 : 8'h40, d, d[11:8] | 4'h1);
      outs();
      wb(1'b0, r ? 8'h44 : 8'h40, $random(seed), d[15:12]);
      check("read back", rd, {24'h0, mdl[r]});
    end
    wb(1'b1, 8'h40, 32'hff, 4'he);
    outs();
    wb(1'b0, 8'h80, 32'h0, 4'hf);
    check("status", rd, 32'h3);
    wb(1'b0, 8'hfc, 32'h0, 4'hf);
    check("unmapped", rd, 32'h0);
    reset_seq();
    test_done();
  end
endmodule
